//--- hdl/ssp_pkg.sv
// constants and types for the spi serial port control block
// ***************************************************************
// How it works
// - a three-bit mode field picks master at clk/4 (000), clk/16 (001), clk/64 (010), sub-clock tick (011), timer tick (100), or slave (101).
// - no shifting happens while the module enable bit is low.
// - in master mode a data register write starts a full-duplex transfer with our own serial clock.
// - in slave mode the data register shifts out and in on clocks from the external master.
// - the transfer-done flag sets at the end of a transfer and stays until software clears it.
// - in master mode a data write during a transfer is dropped and sets the sticky write-collision flag; in slave mode it is loaded.
// - with chip-select enable low the chip-select pin floats; high, it is the active select.
// - in slave mode the first output bit is ready at chip-select assertion, per polarity and edge.
// - the block keeps running in idle modes while its clock runs.
// - polarity bit high idles the serial clock low; low idles it high.
// - the bit-order bit picks msb or lsb first, matching the far end.
// ***************************************************************
package ssp_pkg;
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'hC;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;
  localparam logic [7:0] CTRL0_RESET = 8'hE0;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam int BIT_CTRL0_EN = 1;
  localparam int BIT_POL = 5;
  localparam int BIT_EDGE = 4;
  localparam int BIT_MSB = 3;
  localparam int BIT_CHIP_SELECT_PIN_ENABLE = 2;
  localparam int BIT_WRITE_COLLISION_FLAG = 1;
  localparam int BIT_TRF = 0;
  localparam logic [2:0] MODE_DIV4 = 3'h0;
  localparam logic [2:0] MODE_DIV16 = 3'h1;
  localparam logic [2:0] MODE_DIV64 = 3'h2;
  localparam logic [2:0] MODE_SUB = 3'h3;
  localparam logic [2:0] MODE_TMR = 3'h4;
  localparam logic [2:0] MODE_SLAVE = 3'h5;
  localparam logic [5:0] HALF_DIV4 = 6'h01;
  localparam logic [5:0] HALF_DIV16 = 6'h07;
  localparam logic [5:0] HALF_DIV64 = 6'h1F;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_TRAIL = 3'b100
  } ssp_state_t;
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic csn;
  } ssp_pins_t;
endpackage

//--- hdl/ssp_spi_port.sv
// spi serial port: avalon-mm registers, master and slave shift engine
`timescale 1ns/1ps
module ssp_spi_port import ssp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic subClkTick,
  input wire logic timerTick,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOe_n,
  input wire logic sdiIn,
  output logic sdoOut,
  output logic sdoOe_n,
  input wire logic csIn_n,
  output logic csOut_n,
  output logic csOe_n
);
  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] shift_data_register;
  logic [1:0] irqMask_reg;
  logic [31:0] readdata_reg;
  logic ack_reg;
  ssp_state_t state_reg;
  logic [3:0] bitCnt_reg;
  logic [5:0] divCnt_reg;
  logic tickPrev_reg;
  ssp_pins_t pins_reg;
  logic [2:0] sclkSync_reg;
  logic [2:0] csSync_reg;
  logic [2:0] sdiSync_reg;
  logic sclkStable_reg;
  logic csStable_reg;
  logic sdiStable_reg;
  logic sampled_reg;

  wire [2:0] operating_mode_field = ctrl0_reg[7:5];
  wire module_enable = ctrl0_reg[BIT_CTRL0_EN];
  wire clock_idle_polarity = ctrl2_reg[BIT_POL];
  wire clock_capture_edge = ctrl2_reg[BIT_EDGE];
  wire bit_order_select = ctrl2_reg[BIT_MSB];
  wire chip_select_pin_enable = ctrl2_reg[BIT_CHIP_SELECT_PIN_ENABLE];
  wire write_collision_flag = ctrl2_reg[BIT_WRITE_COLLISION_FLAG];
  wire transfer_done_flag = ctrl2_reg[BIT_TRF];
  wire isSlave = (operating_mode_field == MODE_SLAVE);
  wire isMaster = (operating_mode_field <= MODE_TMR);
  // sclk idle level: polarity high idles low
  wire idleLevel = ~clock_idle_polarity;
  // capture on the first edge leaving idle when capture-edge bit set, else on the second edge
  wire busy = (state_reg != ST_IDLE);

  // ***************************************************************
  // bus decode
  // ***************************************************************
  wire reqLive = read | write;
  // the waitrequest-high cycle registers the request and latches read data; a write takes effect once waitrequest is low
  assign waitrequest = reqLive & ~ack_reg;
  wire accept = reqLive & ack_reg;
  wire wrCtrl0 = accept & write & (address == ADDR_CTRL0);
  wire wrCtrl2 = accept & write & (address == ADDR_CTRL2);
  wire wrData = accept & write & (address == ADDR_DATA);
  wire wrStat = accept & write & (address == ADDR_IRQ_STAT);
  wire wrMask = accept & write & (address[3:2] == 2'h3) & (address[1:0] != 2'h0);
  logic [31:0] rdMux;
  always_comb begin
    if (address == ADDR_CTRL0) begin
      rdMux = {24'h000000, ctrl0_reg[7:5], 1'b0, ctrl0_reg[3:0]};
    end else if (address == ADDR_CTRL2) begin
      rdMux = {24'h000000, 2'b00, ctrl2_reg[5:0]};
    end else if (address == ADDR_DATA) begin
      rdMux = {24'h000000, shift_data_register};
    end else if (address == ADDR_IRQ_STAT) begin
      rdMux = {24'h000000, 4'h0, irqMask_reg, write_collision_flag, transfer_done_flag};
    end else begin
      rdMux = 32'h00000000;
    end
  end
  assign readdata = readdata_reg;

  // ***************************************************************
  // clock sources and synchronisers
  // ***************************************************************
  wire [5:0] halfDiv = (operating_mode_field == MODE_DIV16) ? HALF_DIV16 :
                       (operating_mode_field == MODE_DIV64) ? HALF_DIV64 : HALF_DIV4;
  wire extTick = (operating_mode_field == MODE_SUB) ? subClkTick : timerTick;
  wire useExt = (operating_mode_field == MODE_SUB) | (operating_mode_field == MODE_TMR);
  // external tick toggles the line, so one serial period spans two ticks
  wire halfTick = useExt ? (extTick & ~tickPrev_reg) : (divCnt_reg == halfDiv);
  // a change counts once stages two and three agree
  wire sclkNow = (sclkSync_reg[1] == sclkSync_reg[2]) ? sclkSync_reg[2] : sclkStable_reg;
  wire csNow = (csSync_reg[1] == csSync_reg[2]) ? csSync_reg[2] : csStable_reg;
  wire sdiNow = (sdiSync_reg[1] == sdiSync_reg[2]) ? sdiSync_reg[2] : sdiStable_reg;
  wire slaveSel = chip_select_pin_enable ? ~csNow : 1'b1;
  wire sEdge = (sclkNow != sclkStable_reg) & slaveSel;
  wire leadEdge = sEdge & (sclkStable_reg == idleLevel);
  // capture edge bit high: sample on the leading edge, else trailing
  wire sampleEdge = clock_capture_edge ? leadEdge : (sEdge & ~leadEdge);
  wire shiftEdge = clock_capture_edge ? (sEdge & ~leadEdge) : leadEdge;
  wire sdiBit = isSlave ? sdiNow : sdiStable_reg;

  // ***************************************************************
  // shift engine
  // ***************************************************************
  wire outBit = bit_order_select ? shift_data_register[7] : shift_data_register[0];
  wire startM = wrData & ~busy & isMaster & module_enable;
  wire collide = wrData & busy;
  wire mLast = (bitCnt_reg == BITS_PER_XFER - 4'h1);
  wire mTick = isMaster & busy & halfTick;
  wire mSample = mTick & (clock_capture_edge ? (state_reg == ST_LEAD) : (state_reg == ST_TRAIL));
  // trailing capture: the first bit is already out, so the first leading edge must not shift
  wire mShift = mTick & (clock_capture_edge ? (state_reg == ST_TRAIL) : ((state_reg == ST_LEAD) & (bitCnt_reg != 4'h0)));
  wire mDone = mTick & (state_reg == ST_TRAIL) & mLast;
  wire sActive = isSlave & module_enable;
  wire sSample = sActive & sampleEdge;
  wire sShift = sActive & shiftEdge & (bitCnt_reg != 4'h0);
  wire sDone = sSample & (bitCnt_reg == BITS_PER_XFER - 4'h1);
  wire doSample = mSample | sSample;
  wire doShift = mShift | sShift | sDone | (mDone & ~clock_capture_edge);
  // a shift on the sampling edge must take the bit being sampled, not the stale one
  wire inBit = doSample ? (isSlave ? sdiBit : sdiIn) : sampled_reg;
  wire [7:0] shifted = bit_order_select ? {shift_data_register[6:0], inBit} :
                       {inBit, shift_data_register[7:1]};
  wire xferDone = mDone | sDone;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
      ctrl0_reg <= CTRL0_RESET;
      ctrl2_reg <= CTRL2_RESET;
      irqMask_reg <= 2'b00;
      shift_data_register <= 8'h00;
    end else begin
      ack_reg <= reqLive & ~ack_reg;
      if (read & ~ack_reg) begin
        readdata_reg <= rdMux;
      end
      if (wrCtrl0) begin
        ctrl0_reg <= {writedata[7:5], 1'b0, writedata[3:0]};
      end
      if (wrMask) begin
        irqMask_reg <= writedata[3:2];
      end
      // set wins over a software clear of the same bit
      ctrl2_reg[BIT_TRF] <= xferDone | (wrCtrl2 ? writedata[BIT_TRF] & transfer_done_flag : transfer_done_flag) & ~(wrStat & writedata[0]);
      ctrl2_reg[BIT_WRITE_COLLISION_FLAG] <= collide | (wrCtrl2 ? writedata[BIT_WRITE_COLLISION_FLAG] & write_collision_flag : write_collision_flag) & ~(wrStat & writedata[1]);
      if (wrCtrl2) begin
        ctrl2_reg[7:2] <= {2'b00, writedata[5:2]};
      end
      if (wrData & ~busy) begin
        shift_data_register <= writedata[7:0];
      end else if (doShift) begin
        shift_data_register <= shifted;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      divCnt_reg <= 6'h00;
      tickPrev_reg <= 1'b0;
      sampled_reg <= 1'b0;
      sclkSync_reg <= 3'b111;
      csSync_reg <= 3'b111;
      sdiSync_reg <= 3'b000;
      sclkStable_reg <= 1'b1;
      csStable_reg <= 1'b1;
      sdiStable_reg <= 1'b0;
      pins_reg <= '{sclk: 1'b1, mosi: 1'b0, csn: 1'b1};
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], sclkIn};
      csSync_reg <= {csSync_reg[1:0], csIn_n};
      sdiSync_reg <= {sdiSync_reg[1:0], sdiIn};
      sclkStable_reg <= sclkNow;
      csStable_reg <= csNow;
      sdiStable_reg <= sdiNow;
      tickPrev_reg <= extTick;
      divCnt_reg <= (halfTick | ~busy) ? 6'h00 : divCnt_reg + 6'h01;
      if (doSample) begin
        sampled_reg <= isSlave ? sdiBit : sdiIn;
      end
      pins_reg.mosi <= outBit;
      if (!module_enable) begin
        state_reg <= ST_IDLE;
        bitCnt_reg <= 4'h0;
        pins_reg.sclk <= idleLevel;
        pins_reg.csn <= 1'b1;
      end else if (isSlave) begin
        state_reg <= ST_IDLE;
        pins_reg.sclk <= idleLevel;
        pins_reg.csn <= 1'b1;
        if (chip_select_pin_enable & csNow) begin
          bitCnt_reg <= 4'h0;
        end else if (sSample) begin
          bitCnt_reg <= sDone ? 4'h0 : bitCnt_reg + 4'h1;
        end
      end else begin
        case (state_reg)
          ST_IDLE: begin
            pins_reg.sclk <= idleLevel;
            pins_reg.csn <= ~startM;
            bitCnt_reg <= 4'h0;
            if (startM) begin
              state_reg <= ST_LEAD;
            end
          end
          ST_LEAD: begin
            if (halfTick) begin
              pins_reg.sclk <= ~idleLevel;
              state_reg <= ST_TRAIL;
            end
          end
          ST_TRAIL: begin
            if (halfTick) begin
              pins_reg.sclk <= idleLevel;
              bitCnt_reg <= bitCnt_reg + 4'h1;
              state_reg <= mLast ? ST_IDLE : ST_LEAD;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // pins and interrupt
  // ***************************************************************
  // the block has no gating of its own, so idle modes stop it only by stopping clk
  assign irq = |({write_collision_flag, transfer_done_flag} & irqMask_reg);
  assign sclkOut = pins_reg.sclk;
  assign sclkOe_n = ~(module_enable & isMaster);
  assign sdoOut = pins_reg.mosi;
  assign sdoOe_n = ~(module_enable & (isMaster | (isSlave & slaveSel)));
  assign csOut_n = pins_reg.csn;
  assign csOe_n = ~(module_enable & isMaster & chip_select_pin_enable);

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_collide;
    @(posedge clk) disable iff (!rst_n) (wrData & busy) |=> write_collision_flag;
  endproperty
  a_collide: assert property (p_collide) else $error("collision flag not set");
  property p_done;
    @(posedge clk) disable iff (!rst_n) xferDone |=> transfer_done_flag;
  endproperty
  a_done: assert property (p_done) else $error("done flag not set");
  property p_enable;
    @(posedge clk) disable iff (!rst_n) !module_enable |=> !busy;
  endproperty
  a_enable: assert property (p_enable) else $error("shifting while disabled");
  property p_start;
    @(posedge clk) disable iff (!rst_n) startM |=> state_reg == ST_LEAD;
  endproperty
  a_start: assert property (p_start) else $error("master did not start");
  property p_idle;
    @(posedge clk) disable iff (!rst_n) (isMaster & module_enable & !busy & $past(!busy) & $stable(idleLevel)) |-> sclkOut == idleLevel;
  endproperty
  a_idle: assert property (p_idle) else $error("sclk not at idle level");
  property p_cs;
    @(posedge clk) disable iff (!rst_n) !chip_select_pin_enable |-> csOe_n;
  endproperty
  a_cs: assert property (p_cs) else $error("chip select driven while disabled");
  property p_count;
    @(posedge clk) disable iff (!rst_n) busy |-> bitCnt_reg < BITS_PER_XFER;
  endproperty
  a_count: assert property (p_count) else $error("bit count overran");
  property p_keep;
    @(posedge clk) disable iff (!rst_n) (wrData & busy) |=> shift_data_register == $past(shift_data_register) || $past(doShift);
  endproperty
  a_keep: assert property (p_keep) else $error("colliding write stored");
endmodule

//--- verif/ssp_spi_partner.sv
// partner model: external spi device, slave to a master block, master to a slave block
`timescale 1ns/1ps
module ssp_spi_partner import ssp_pkg::*; (
  input wire logic clk,
  input wire logic role,
  input wire logic [7:0] txByte,
  input wire logic pol,
  input wire logic capLead,
  input wire logic msbFirst,
  input wire logic sclkW,
  input wire logic csW_n,
  input wire logic doutW,
  output logic sclkDrv,
  output logic csDrv_n,
  output logic sdiDrv,
  output logic [7:0] rxByte
);
  // ****
  // slow half period so the block's pin synchronisers keep up
  // ****
  localparam int HALF = 8;
  int n = 0;
  logic active = 1'b0;
  logic sclkPh = 1'b0;
  initial csDrv_n = 1'b1;
  initial sdiDrv = 1'b0;
  assign sclkDrv = active ? sclkPh : !pol;
  function automatic int idx(input int i);
    return msbFirst ? 7 - i : i;
  endfunction
  always @(negedge csW_n) begin
    if (!role) begin
      n = 0;
      if (capLead) begin
        sdiDrv = txByte[idx(0)];
      end
    end
  end
  always @(sclkW) begin
    if (!role && csW_n === 1'b0) begin
      if ((sclkW === pol) == capLead) begin
        rxByte[idx(n)] = doutW;
        n = n + 1;
      end else if (n < 8) begin
        sdiDrv = txByte[idx(n)];
      end
    end
  end
  // a released line must not keep showing its last bit
  always @(posedge csW_n) begin
    if (!role) begin
      sdiDrv = !sdiDrv;
    end
  end
  task automatic master_xfer();
    @(posedge clk);
    active <= 1'b1;
    sclkPh <= !pol;
    csDrv_n <= 1'b0;
    sdiDrv <= txByte[idx(0)];
    repeat (HALF) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      sclkPh <= pol;
      if (capLead) rxByte[idx(i)] <= doutW;
      else sdiDrv <= txByte[idx(i)];
      repeat (HALF) @(posedge clk);
      sclkPh <= !pol;
      if (!capLead) rxByte[idx(i)] <= doutW;
      else if (i < 7) sdiDrv <= txByte[idx(i + 1)];
      repeat (HALF) @(posedge clk);
    end
    csDrv_n <= 1'b1;
    active <= 1'b0;
    sdiDrv <= !sdiDrv;
  endtask
endmodule

//--- verif/tb_ssp_spi_port.sv
// testbench: register access, master and slave transfers against the partner model
`timescale 1ns/1ps
module tb_ssp_spi_port import ssp_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic role = 1'b0, pol = 1'b0, capLead = 1'b0, msbFirst = 1'b1, s1, s2;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q, c2;
  logic waitrequest, irq, sclkOut, sclkOe_n, sdoOut, sdoOe_n, csOut_n, csOe_n;
  logic sclkDrv, csDrv_n, sdiDrv, sclkW, csW_n;
  logic tick = 1'b0;
  logic [7:0] txByte = 8'h00, rxByte;
  int miscompares = 0, samples_checked = 0, n;
  always #5 clk = !clk;
  always @(posedge clk) tick <= !tick;
  assign sclkW = sclkOe_n ? sclkDrv : sclkOut;
  assign csW_n = csOe_n ? csDrv_n : csOut_n;
  ssp_spi_port dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .subClkTick(tick), .timerTick(tick), .sclkIn(sclkW),
    .sclkOut(sclkOut), .sclkOe_n(sclkOe_n), .sdiIn(sdiDrv), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .csIn_n(csW_n),
    .csOut_n(csOut_n), .csOe_n(csOe_n));
  ssp_spi_partner pm (.clk(clk), .role(role), .txByte(txByte), .pol(pol), .capLead(capLead), .msbFirst(msbFirst),
    .sclkW(sclkW), .csW_n(csW_n), .doutW(sdoOut), .sclkDrv(sclkDrv), .csDrv_n(csDrv_n), .sdiDrv(sdiDrv),
    .rxByte(rxByte));
  // ****
  // bus and check tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    q = 32'h0;
    while (q[BIT_TRF] !== 1'b1 && k < 200) begin
      acc(1'b0, ADDR_CTRL2, 32'h0);
      k++;
    end
    chk(q[BIT_TRF], 1'b1);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, ADDR_CTRL0, 32'h0);
    chk(q[7:0], CTRL0_RESET);
    acc(1'b0, ADDR_CTRL2, 32'h0);
    chk({q[7:0], irq, sclkOe_n, csOe_n}, {CTRL2_RESET, 3'h3});
    acc(1'b0, 4'h6, 32'h0);
    chk(q, 32'h0);
    // enable still low: a data write must not start anything
    acc(1'b1, ADDR_CTRL2, 32'h4);
    acc(1'b1, ADDR_CTRL0, {24'h0, MODE_DIV4, 5'h00});
    acc(1'b1, ADDR_DATA, 32'h5A);
    repeat (40) @(posedge clk);
    acc(1'b0, ADDR_CTRL2, 32'h0);
    chk({q[1:0], csOut_n, sclkOe_n}, 4'h3);
    // fastest divider, chip-select pin left floating
    acc(1'b1, 4'hD, 32'h4);
    acc(1'b1, ADDR_CTRL2, 32'h0);
    acc(1'b1, ADDR_CTRL0, {24'h0, MODE_DIV4, 5'h02});
    acc(1'b1, ADDR_DATA, 32'hC3);
    n = 0;
    while (sclkOut !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    s1 = sclkOut;
    @(posedge clk);
    s2 = sclkOut;
    repeat (2) @(posedge clk);
    chk({s1, s2, sclkOut, csOe_n}, 4'h5);
    wait_done();
    chk(irq, 1'b1);
    acc(1'b1, ADDR_IRQ_STAT, 32'h1);
    @(posedge clk);
    chk(irq, 1'b0);
    // tick-driven master clocks: a transfer only finishes if the tick source is used
    acc(1'b1, ADDR_CTRL0, {24'h0, MODE_SUB, 5'h02});
    acc(1'b1, ADDR_DATA, 32'h3C);
    wait_done();
    acc(1'b1, ADDR_CTRL2, 32'h0);
    acc(1'b1, ADDR_CTRL0, {24'h0, MODE_TMR, 5'h02});
    acc(1'b1, ADDR_DATA, 32'hA5);
    wait_done();
    for (int k = 0; k < 4; k++) begin
      c2 = {26'h0, k[1], k[0], !k[0], 3'h4};
      pol <= k[1];
      capLead <= k[0];
      msbFirst <= !k[0];
      role <= 1'b0;
      txByte <= 8'h96 ^ 8'(k);
      acc(1'b1, ADDR_CTRL2, c2);
      acc(1'b1, ADDR_CTRL0, {24'h0, MODE_DIV16, 5'h02});
      @(posedge clk);
      chk(sclkOut, !k[1]);
      acc(1'b1, ADDR_DATA, {24'h0, 8'h3C ^ 8'(k)});
      acc(1'b1, ADDR_DATA, 32'hFF);
      chk(csOe_n, 1'b0);
      chk(sdoOe_n, 1'b0);
      wait_done();
      chk({q[BIT_WRITE_COLLISION_FLAG], irq}, 2'h3);
      chk(rxByte, 8'h3C ^ 8'(k));
      acc(1'b0, ADDR_DATA, 32'h0);
      chk(q[7:0], 8'h96 ^ 8'(k));
      role <= 1'b1;
      txByte <= 8'h69 ^ 8'(k);
      acc(1'b1, ADDR_CTRL2, c2);
      acc(1'b1, ADDR_CTRL0, {24'h0, MODE_SLAVE, 5'h02});
      acc(1'b1, ADDR_DATA, {24'h0, 8'hE1 ^ 8'(k)});
      chk(sdoOe_n, 1'b1);
      pm.master_xfer();
      wait_done();
      chk(rxByte, 8'hE1 ^ 8'(k));
      acc(1'b0, ADDR_DATA, 32'h0);
      chk(q[7:0], 8'h69 ^ 8'(k));
      acc(1'b1, 4'hD, 32'h0);
      @(posedge clk);
      chk(irq, 1'b0);
      acc(1'b1, 4'hD, 32'h4);
      acc(1'b1, ADDR_CTRL2, c2);
      acc(1'b0, ADDR_CTRL2, 32'h0);
      chk({q[1:0], irq}, 3'h0);
    end
    results();
  end
endmodule
